// [adcrp_port.sv]

module adcrp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p);
    ptr_step = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign push = in_valid_in && in_ready_out;
  assign pop = out_ready_in && out_valid_out;
  assign out_data_out = mem_r[rd_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      if (push) begin
        wr_r <= ptr_step(wr_r);
      end
      if (pop) begin
        rd_r <= ptr_step(rd_r);
      end
      cnt_r <= cnt_nxt;
      in_ready_out <= (cnt_nxt != CNT_FULL);
      out_valid_out <= (cnt_nxt != '0);
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_r] <= in_data_in;
    end
  end
endmodule

module adcrp_port
  import adcrp_pkg::*;
#(
  parameter int RES_BITS = RES_BITS_DEFAULT,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic frame_sel_n_in,
  input wire logic serial_clk_in,
  input wire logic frame_length_select_in,
  input wire logic output_lane_select_in,
  input wire adcrp_sample_t result_in,
  input wire logic result_valid_in,
  output logic result_ready_out,
  output logic serial_out_a_out,
  output logic serial_out_a_oe_out,
  output logic serial_out_b_out,
  output logic serial_out_b_oe_out,
  output logic sampling_out,
  output logic converting_out
);
  localparam int CONV_CYC = (RES_BITS == 16) ? CONV_CYC_WIDE : CONV_CYC_NARROW;
  localparam logic [6:0] CONV_LOAD = 7'(CONV_CYC - 1);

  logic sel_meta_r;
  logic sel_sync_r;
  logic sel_prev_r;
  logic sclk_meta_r;
  logic sclk_sync_r;
  logic sclk_prev_r;
  logic frame_start;
  logic frame_end;
  logic sclk_fall;

  adcrp_state_t state_r;
  logic [1:0] fmt_r;
  logic [1:0] fmt_req;
  logic [6:0] conv_cnt_r;
  logic conv_done;
  logic [5:0] edge_r;
  logic [5:0] edge_nxt;
  logic [5:0] msb_edge;
  logic [5:0] pos;
  logic in_data;
  logic bit_a;
  logic bit_b;
  adcrp_sample_t word_r;
  adcrp_sample_t fifo_data;
  logic fifo_valid;

  adcrp_fifo #(
    .WIDTH($bits(adcrp_sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .in_data_in(result_in),
    .in_valid_in(result_valid_in),
    .in_ready_out(result_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(conv_done)
  );

  // bit p after the MSB of a result, zero once the result is exhausted
  function automatic logic lane_bit(input logic [RESULT_W-1:0] w, input logic [5:0] p);
    lane_bit = 1'b0;
    if (p < 6'(RES_BITS)) begin
      lane_bit = w[4'(RES_BITS - 1) - p[3:0]];
    end
  endfunction

  // format code decode shared by the launch, timing and enable logic
  function automatic logic fmt_is_short(input logic [1:0] f);
    fmt_is_short = f[1];
  endfunction

  function automatic logic fmt_is_single(input logic [1:0] f);
    fmt_is_single = f[0];
  endfunction

  // frame select and serial clock pins cross into the core clock through two flops each
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sel_meta_r <= SYNC_RST_SEL;
      sel_sync_r <= SYNC_RST_SEL;
      sel_prev_r <= SYNC_RST_SEL;
    end else begin
      sel_meta_r <= frame_sel_n_in;
      sel_sync_r <= sel_meta_r;
      sel_prev_r <= sel_sync_r;
    end
  end

  // reset levels match the idle pins so no false edge follows reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sclk_meta_r <= SYNC_RST_CLK;
      sclk_sync_r <= SYNC_RST_CLK;
      sclk_prev_r <= SYNC_RST_CLK;
    end else begin
      sclk_meta_r <= serial_clk_in;
      sclk_sync_r <= sclk_meta_r;
      sclk_prev_r <= sclk_sync_r;
    end
  end

  assign frame_start = sel_prev_r && !sel_sync_r;
  assign frame_end = !sel_prev_r && sel_sync_r;
  assign sclk_fall = sclk_prev_r && !sclk_sync_r && !sel_sync_r && !frame_start;

  // 16-bit builds fold the 16-clock codes back onto the 32-clock formats
  always_comb begin
    fmt_req = {frame_length_select_in, output_lane_select_in};
    if (RES_BITS == 16) begin
      fmt_req[1] = 1'b0;
    end
  end

  assign msb_edge = fmt_is_short(fmt_r) ? MSB_EDGE_16 : MSB_EDGE_32;
  assign edge_nxt = (edge_r == EDGE_MAX) ? edge_r : 6'(edge_r + 1'b1);
  assign pos = 6'(edge_nxt - msb_edge);
  assign in_data = (edge_nxt >= msb_edge) && (state_r == ST_SHIFT);

  always_comb begin
    bit_a = 1'b0;
    bit_b = 1'b0;
    if (in_data) begin
      if (!fmt_is_single(fmt_r)) begin
        bit_a = lane_bit(word_r.res_a, pos);
        bit_b = lane_bit(word_r.res_b, pos);
      end else if (pos < LANE_B_SHIFT) begin
        bit_a = lane_bit(word_r.res_a, pos);
      end else begin
        bit_a = lane_bit(word_r.res_b, 6'(pos - LANE_B_SHIFT));
      end
    end
  end

  // 32-clock formats end on the internal timer, 16-clock ones on serial edge 1
  assign conv_done = (state_r == ST_CONVERT) && !frame_end &&
                     (fmt_is_short(fmt_r) ? sclk_fall : (conv_cnt_r == '0));

  // frame end wins over everything, a cut frame drops back to idle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= ST_IDLE;
    end else if (frame_end) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (frame_start) begin
            state_r <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (conv_done) begin
            state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (frame_start) begin
            state_r <= ST_CONVERT;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // format is taken once per frame, changes mid-frame wait for the next one
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fmt_r <= FMT_RESET;
    end else if (frame_start) begin
      fmt_r <= fmt_req;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      conv_cnt_r <= '0;
    end else if (frame_start) begin
      conv_cnt_r <= CONV_LOAD;
    end else if (conv_cnt_r != '0) begin
      conv_cnt_r <= 7'(conv_cnt_r - 1'b1);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      word_r <= SAMPLE_RESET;
    end else if (conv_done) begin
      word_r <= fifo_valid ? fifo_data : SAMPLE_RESET;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      edge_r <= EDGE_RESET;
    end else if (frame_start) begin
      edge_r <= EDGE_RESET;
    end else if (sclk_fall) begin
      edge_r <= edge_nxt;
    end
  end

  // sample-and-hold: holds from frame start until conversion ends
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sampling_out <= 1'b1;
    end else if (frame_start) begin
      sampling_out <= 1'b0;
    end else if (conv_done || frame_end) begin
      sampling_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      converting_out <= 1'b0;
    end else if (frame_start) begin
      converting_out <= 1'b1;
    end else if (conv_done || frame_end) begin
      converting_out <= 1'b0;
    end
  end

  // lane data moves on counted falling edges and clears at frame start and end, enables follow the frame
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      serial_out_a_out <= 1'b0;
    end else if (frame_start) begin
      serial_out_a_out <= 1'b0;
    end else if (frame_end) begin
      serial_out_a_out <= 1'b0;
    end else if (sclk_fall) begin
      serial_out_a_out <= bit_a;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      serial_out_a_oe_out <= 1'b0;
    end else if (frame_start) begin
      serial_out_a_oe_out <= 1'b1;
    end else if (frame_end) begin
      serial_out_a_oe_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      serial_out_b_out <= 1'b0;
    end else if (frame_start) begin
      serial_out_b_out <= 1'b0;
    end else if (frame_end) begin
      serial_out_b_out <= 1'b0;
    end else if (sclk_fall) begin
      serial_out_b_out <= bit_b;
    end
  end

  // single lane formats never enable lane b
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      serial_out_b_oe_out <= 1'b0;
    end else if (frame_start) begin
      serial_out_b_oe_out <= !fmt_is_single(fmt_req);
    end else if (frame_end) begin
      serial_out_b_oe_out <= 1'b0;
    end
  end
endmodule

// [adcrp_pkg.sv]
package adcrp_pkg;

  // core clock and conversion timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_NS_WIDE = 640;
  localparam int CONV_NS_NARROW = 450;
  // longest times round down to whole cycles
  localparam int CONV_CYC_WIDE = CONV_NS_WIDE / CLK_PERIOD_NS;
  localparam int CONV_CYC_NARROW = CONV_NS_NARROW / CLK_PERIOD_NS;

  // configuration_word format codes {frame_length_select, output_lane_select}
  localparam logic [1:0] FMT_32_DUAL = 2'h0;
  localparam logic [1:0] FMT_32_SINGLE = 2'h1;
  localparam logic [1:0] FMT_16_DUAL = 2'h2;
  localparam logic [1:0] FMT_16_SINGLE = 2'h3;
  localparam logic [1:0] FMT_RESET = FMT_32_DUAL;

  // least falling edges the host owes per frame, by format
  localparam int MIN_EDGES_32_DUAL = 32;
  localparam int MIN_EDGES_32_SINGLE = 48;
  localparam int MIN_EDGES_16_DUAL = 16;
  localparam int MIN_EDGES_16_SINGLE = 32;

  // falling edge numbers that launch data
  localparam logic [5:0] MSB_EDGE_32 = 6'h10;
  localparam logic [5:0] MSB_EDGE_16 = 6'h02;
  localparam logic [5:0] LANE_B_SHIFT = 6'h10;
  localparam logic [5:0] EDGE_MAX = 6'h3f;
  localparam logic [5:0] EDGE_RESET = 6'h00;

  // synchroniser reset levels: frame select idles high
  localparam logic SYNC_RST_SEL = 1'b1;
  localparam logic SYNC_RST_CLK = 1'b0;

  localparam int RESULT_W = 16;
  localparam int RES_BITS_DEFAULT = 16;
  localparam int FIFO_DEPTH_DEFAULT = 8;

  typedef struct packed {
    logic [RESULT_W-1:0] res_a;
    logic [RESULT_W-1:0] res_b;
  } adcrp_sample_t;

  localparam adcrp_sample_t SAMPLE_RESET = '0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_SHIFT
  } adcrp_state_t;

endpackage

// [adcrp_checker.sv]
module adcrp_checker (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic frame_sel_n_in,
  input wire logic serial_clk_in,
  input wire logic output_lane_select_in,
  input wire logic serial_out_a_out,
  input wire logic serial_out_a_oe_out,
  input wire logic serial_out_b_out,
  input wire logic serial_out_b_oe_out,
  input wire logic sampling_out,
  input wire logic converting_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_idle_tristate: assert property (
    frame_sel_n_in [*6] |-> !serial_out_a_oe_out && !serial_out_b_oe_out)
    else $error("lane driven outside a frame");
  a_start_drive: assert property (
    $fell(frame_sel_n_in) |-> ##[3:5] (serial_out_a_oe_out && !serial_out_a_out))
    else $error("frame start did not drive lane a low");
  a_conv_quiet: assert property (
    converting_out |-> !serial_out_a_out && !serial_out_b_out)
    else $error("lane data high while converting");
  a_conv_bound: assert property (
    $rose(converting_out) |-> ##[56:66] $fell(converting_out))
    else $error("conversion overran its interval");
  a_hold_conv: assert property (
    converting_out |-> !sampling_out)
    else $error("tracking while converting");
  a_track_after: assert property (
    $fell(converting_out) && !frame_sel_n_in |-> sampling_out)
    else $error("no tracking after conversion");
  a_single_b_off: assert property (
    $rose(serial_out_a_oe_out) && $past(output_lane_select_in) |-> !serial_out_b_oe_out)
    else $error("lane b driven in single lane format");
  a_dual_b_on: assert property (
    $rose(serial_out_a_oe_out) && !$past(output_lane_select_in) |-> serial_out_b_oe_out)
    else $error("lane b not driven in dual lane format");
  a_b_with_a: assert property (
    $rose(serial_out_b_oe_out) |-> $rose(serial_out_a_oe_out))
    else $error("lane b enabled away from frame start");
  a_launch_low: assert property (
    $changed(serial_out_a_out) && !frame_sel_n_in && $past(serial_out_a_oe_out)
      |-> !serial_clk_in)
    else $error("lane a changed outside a falling edge");
  c_conv_end: cover property ($fell(converting_out));
  c_single: cover property (serial_out_a_oe_out && output_lane_select_in);
  c_b_data: cover property (serial_out_b_oe_out && serial_out_b_out);
endmodule
bind adcrp_port adcrp_checker u_chk (.clk_in, .rstn_in, .frame_sel_n_in,
  .serial_clk_in, .output_lane_select_in, .serial_out_a_out, .serial_out_a_oe_out,
  .serial_out_b_out, .serial_out_b_oe_out, .sampling_out, .converting_out);

// [adcrp_host.sv]
module adcrp_host (
  input wire logic a_in,
  input wire logic a_oe_in,
  input wire logic b_in,
  input wire logic b_oe_in,
  output logic frame_sel_n_out,
  output logic serial_clk_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] lane_a [0:48];
  logic [1:0] lane_b [0:48];
  initial begin
    frame_sel_n_out = 1'b1;
    serial_clk_out = 1'b0;
  end
  // lanes read as {enable, data} half a period after each launch edge
  // an undriven lane reads inverted so a missing enable cannot pass
  task automatic run_frame(input int edges);
    frame_sel_n_out = 1'b0;
    #200;
    for (int k = 0; k <= edges; k++) begin
      #62.5;
      lane_a[k] = {a_oe_in, a_oe_in ? a_in : !a_in};
      lane_b[k] = {b_oe_in, b_oe_in ? b_in : !b_in};
      if (k < edges) begin
        serial_clk_out = 1'b1;
        #62.5;
        serial_clk_out = 1'b0;
      end
    end
    frame_sel_n_out = 1'b1;
    #500;
  endtask
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #62.5 serial_clk_out = 1'b1;
      #62.5 serial_clk_out = 1'b0;
    end
  endtask
endmodule

// [adcrp_port_bench.sv]
module adcrp_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import adcrp_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic len_sel = 1'b0;
  logic lane_sel = 1'b0;
  logic valid = 1'b0;
  adcrp_sample_t result = SAMPLE_RESET;
  logic ready, a_out, a_oe, b_out, b_oe, sampling, converting, frame_sel_n, sclk;
  int err_count = 0;
  int compares = 0;
  always #5 clk_in = ~clk_in;
  adcrp_port u_dut (.clk_in, .rstn_in, .frame_sel_n_in(frame_sel_n),
    .serial_clk_in(sclk), .frame_length_select_in(len_sel),
    .output_lane_select_in(lane_sel), .result_in(result), .result_valid_in(valid),
    .result_ready_out(ready), .serial_out_a_out(a_out), .serial_out_a_oe_out(a_oe),
    .serial_out_b_out(b_out), .serial_out_b_oe_out(b_oe), .sampling_out(sampling),
    .converting_out(converting));
  adcrp_host u_host (.a_in(a_out), .a_oe_in(a_oe), .b_in(b_out), .b_oe_in(b_oe),
    .frame_sel_n_out(frame_sel_n), .serial_clk_out(sclk));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic adcrp_sample_t val(input int i);
    val.res_a = {4'h9, i[3:0], 8'h3c};
    val.res_b = {8'hc3, i[3:0], 4'h5};
  endfunction
  task automatic test_fill();
    int taken;
    taken = 0;
    valid = 1'b1;
    for (int i = 0; i < 9; i++) begin
      result = val(i);
      if (ready === 1'b1) taken++;
      @(posedge clk_in);
      #1;
    end
    valid = 1'b0;
    check(taken, 8);
    check(ready, 1'b0);
  endtask
  task automatic test_frames();
    adcrp_sample_t e;
    logic dual, ab, bb;
    int n;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_in);
      #1;
      {len_sel, lane_sel} = i[1:0];
      e = (i < 8) ? val(i) : SAMPLE_RESET;
      dual = ~lane_sel;
      n = dual ? 32 : 48;
      u_host.run_frame(n);
      for (int k = 0; k <= n; k++) begin
        ab = (k >= 16 && k < 32) ? e.res_a[31-k] : 1'b0;
        bb = (k >= 16 && k < 32) ? e.res_b[31-k] : 1'b0;
        if (!dual && k >= 32 && k < 48) ab = e.res_b[47-k];
        check({u_host.lane_a[k], u_host.lane_b[k][1], u_host.lane_b[k][0] & dual},
          {1'b1, ab, dual, bb & dual});
      end
      check({a_oe, b_oe, sampling, converting}, 4'h2);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    @(posedge clk_in);
    #1;
    check({sampling, converting, a_oe, b_oe, ready}, 5'h11);
    test_fill();
    u_host.idle_clocks(4);
    check({a_oe, b_oe}, 2'h0);
    test_frames();
    final_report();
  end
  initial begin
    #150000;
    err_count++;
    final_report();
  end
endmodule
